// [scp_pkg.sv]
package scp_pkg;
    // operating modes
    localparam logic [1:0] SCP_MODE_REAL = 2'h0;
    localparam logic [1:0] SCP_MODE_PROT = 2'h1;
    localparam logic [1:0] SCP_MODE_V86  = 2'h2;
    // privilege levels
    localparam logic [1:0] SCP_LVL_KERNEL = 2'h0;
    localparam logic [1:0] SCP_LVL_USER   = 2'h3;
    // register offsets
    localparam logic [7:0] SCP_REG_CTRL     = 8'h00;
    localparam logic [7:0] SCP_REG_FLAGS    = 8'h04;
    localparam logic [7:0] SCP_REG_GDT_BASE = 8'h08;
    localparam logic [7:0] SCP_REG_LDT_BASE = 8'h0c;
    localparam logic [7:0] SCP_REG_STATUS   = 8'h10;
    localparam logic [7:0] SCP_REG_FAULTS   = 8'h14;
    // register fields
    localparam int SCP_CTRL_MODE_LSB  = 0;
    localparam int SCP_CTRL_TASK32    = 2;
    localparam int SCP_FLAGS_IF       = 9;
    localparam int SCP_FLAGS_IOLVL    = 12;
    localparam int SCP_STAT_BUSY      = 2;
    localparam int SCP_STAT_VEC_LSB   = 8;
    // selector fields
    localparam int SCP_SEL_RQ_LSB     = 0;
    localparam int SCP_SEL_TABLE      = 2;
    localparam int SCP_SEL_INDEX_LSB  = 3;
    // descriptor fields
    localparam int SCP_D_LIMLO_LSB    = 0;
    localparam int SCP_D_BASELO_LSB   = 16;
    localparam int SCP_D_TYPE_LSB     = 40;
    localparam int SCP_D_S            = 44;
    localparam int SCP_D_DLVL_LSB     = 45;
    localparam int SCP_D_P            = 47;
    localparam int SCP_D_LIMHI_LSB    = 48;
    localparam int SCP_D_FLAGS_LSB    = 52;
    localparam int SCP_D_G            = 55;
    localparam int SCP_D_BASEHI_LSB   = 56;
    // fixed cache contents for real and v86 modes, granularity limit fill and cache entry count
    localparam logic [31:0] SCP_FIXED_LIMIT = 32'h0000ffff;
    localparam logic [11:0] SCP_ATTR_REAL   = 12'h093;
    localparam logic [11:0] SCP_ATTR_V86    = 12'h0f3;
    localparam logic [11:0] SCP_LIM_FILL    = 12'hfff;
    localparam int          SCP_NUM_SEGS    = 6;
    // exception vectors
    localparam logic [7:0] SCP_VEC_GP = 8'h0d;
    localparam logic [7:0] SCP_VEC_NP = 8'h0b;
    // checked operations
    typedef enum logic [3:0] {
        SCP_OP_IO, SCP_OP_CLEAR_INTR_FLAG, SCP_OP_SET_INTR_FLAG, SCP_OP_LOCK,
        SCP_OP_FLAGS_LOAD, SCP_OP_ADJUST_SELECTOR_PRIV, SCP_OP_VERIFY_READ,
        SCP_OP_VERIFY_WRITE, SCP_OP_LOAD_LIMIT, SCP_OP_LOAD_RIGHTS,
        SCP_OP_DATA_ACCESS, SCP_OP_CALL_CODE
    } scp_op_t;
    // descriptor fetch states
    typedef enum logic [1:0] {
        SCP_ST_IDLE  = 2'b00,
        SCP_ST_FETCH = 2'b01
    } scp_state_t;
endpackage

// [scp_priv_check.sv]
`timescale 1ns/1ps
module scp_priv_check (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // register port
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [31:0]            reg_rdata_o,
    // segment register load
    input  wire logic              seg_load_i,
    input  wire logic [2:0]        seg_idx_i,
    input  wire logic [15:0]       seg_sel_i,
    output logic                   seg_busy_o,
    // descriptor fetch
    output logic                   desc_req_o,
    output logic [31:0]            desc_addr_o,
    input  wire logic              desc_ack_i,
    input  wire logic [63:0]       desc_data_i,
    // cache readout
    input  wire logic [2:0]        cache_idx_i,
    output logic [31:0]            cache_base_o,
    output logic [31:0]            cache_limit_o,
    output logic [11:0]            cache_attr_o,
    // gate transfer
    input  wire logic              gate_xfer_i,
    input  wire logic [1:0]        gate_lvl_i,
    // operation check
    input  wire logic              op_valid_i,
    input  wire scp_pkg::scp_op_t  op_code_i,
    input  wire logic [15:0]       op_sel_i,
    input  wire logic [1:0]        op_reg_rq_i,
    input  wire logic [63:0]       op_desc_i,
    input  wire logic              op_bitmap_ok_i,
    input  wire logic              op_if_i,
    // operation answer
    output logic                   op_done_o,
    output logic                   op_zf_o,
    output logic [31:0]            op_result_o,
    output logic                   fault_o,
    output logic [7:0]             fault_vec_o,
    // privilege state
    output logic [1:0]             current_priv_level_o,
    output logic                   intr_flag_o
);
    import scp_pkg::*;

    // control and flags state
    logic [1:0]  mode_q;
    logic        task32_q;
    logic [1:0]  io_priv_level_q;
    logic        if_q;
    logic [1:0]  task_lvl_q;
    logic [31:0] gdt_base_q;
    logic [31:0] ldt_base_q;
    logic [7:0]  last_vec_q;
    logic [15:0] fault_cnt_q;

    // segment cache
    logic [31:0] seg_base_q  [SCP_NUM_SEGS];
    logic [31:0] seg_limit_q [SCP_NUM_SEGS];
    logic [11:0] seg_attr_q  [SCP_NUM_SEGS];
    scp_state_t  state_q;
    logic [2:0]  pend_idx_q;
    logic [15:0] pend_sel_q;

    // register decode
    wire wr_ctrl  = reg_wr_i && (reg_addr_i == SCP_REG_CTRL);
    wire wr_flags = reg_wr_i && (reg_addr_i == SCP_REG_FLAGS);
    wire wr_gdt   = reg_wr_i && (reg_addr_i == SCP_REG_GDT_BASE);
    wire wr_ldt   = reg_wr_i && (reg_addr_i == SCP_REG_LDT_BASE);

    // privilege derived from mode
    wire [1:0] cur_lvl = (mode_q == SCP_MODE_REAL) ? SCP_LVL_KERNEL :
                         (mode_q == SCP_MODE_V86)  ? SCP_LVL_USER   : task_lvl_q;
    wire [1:0] requested_priv_level = op_sel_i[SCP_SEL_RQ_LSB +: 2];
    wire [1:0] effective_priv_level = (requested_priv_level > cur_lvl) ?
                                      requested_priv_level : cur_lvl;
    wire       io_pass = (cur_lvl <= io_priv_level_q);

    // descriptor field decode for the op operand
    wire [1:0] descriptor_priv_level = op_desc_i[SCP_D_DLVL_LSB +: 2];
    wire [3:0] d_type   = op_desc_i[SCP_D_TYPE_LSB +: 4];
    wire       d_pres   = op_desc_i[SCP_D_P];
    wire       d_user   = op_desc_i[SCP_D_S];
    wire       d_code   = d_user && d_type[3];
    wire       d_conf   = d_code && d_type[2];
    wire       d_read   = d_user && (!d_type[3] || d_type[1]);
    wire       d_write  = d_user && !d_type[3] && d_type[1];
    wire       data_ok  = (effective_priv_level <= descriptor_priv_level);
    wire       call_ok  = (cur_lvl >= descriptor_priv_level);
    wire       sys_lim  = !d_user && (d_type == 4'h1 || d_type == 4'h2 || d_type == 4'h3 ||
                                      d_type == 4'h9 || d_type == 4'hb);
    wire       sys_rgt  = sys_lim || (!d_user && (d_type == 4'h4 || d_type == 4'h5 || d_type == 4'hc));
    wire       lim_ok   = (d_user || sys_lim) && (data_ok || d_conf);
    wire       rgt_ok   = (d_user || sys_rgt) && (data_ok || d_conf);
    wire       rd_ok    = d_pres && d_read && (data_ok || d_conf);
    wire       wr_ok    = d_pres && d_write && data_ok;

    // limit expansion with granularity
    wire [19:0] op_lim20 = {op_desc_i[SCP_D_LIMHI_LSB +: 4], op_desc_i[SCP_D_LIMLO_LSB +: 16]};
    wire [31:0] op_limit = op_desc_i[SCP_D_G] ? {op_lim20, SCP_LIM_FILL} : {12'h000, op_lim20};
    wire [31:0] op_rights = {8'h00, op_desc_i[SCP_D_FLAGS_LSB +: 4], 4'h0,
                             op_desc_i[SCP_D_TYPE_LSB +: 8], 8'h00};
    wire        adj_change = (requested_priv_level < op_reg_rq_i);
    wire [31:0] adj_sel = {16'h0000, op_sel_i[15:2], adj_change ? op_reg_rq_i : requested_priv_level};

    // per-operation outcome, combinational
    logic        chk_fault;
    logic        chk_zf;
    logic [31:0] chk_result;
    logic        chk_if_we;
    logic        chk_if_val;
    always_comb begin
        chk_fault  = 1'b0;
        chk_zf     = 1'b0;
        chk_result = 32'h0000_0000;
        chk_if_we  = 1'b0;
        chk_if_val = if_q;
        case (op_code_i)
            SCP_OP_IO: begin
                // legacy task has no bitmap to fall back on
                chk_fault = !io_pass && !(task32_q && op_bitmap_ok_i);
            end
            SCP_OP_CLEAR_INTR_FLAG: begin
                chk_fault  = !io_pass;
                chk_if_we  = io_pass;
                chk_if_val = 1'b0;
            end
            SCP_OP_SET_INTR_FLAG: begin
                chk_fault  = !io_pass;
                chk_if_we  = io_pass;
                chk_if_val = 1'b1;
            end
            SCP_OP_LOCK: begin
                chk_fault = 1'b0;
            end
            SCP_OP_FLAGS_LOAD: begin
                // IF update silently ignored when io_pass is low, no fault
                chk_if_we  = io_pass;
                chk_if_val = op_if_i;
            end
            SCP_OP_ADJUST_SELECTOR_PRIV: begin
                chk_zf     = adj_change;
                chk_result = adj_sel;
            end
            SCP_OP_VERIFY_READ: begin
                chk_zf = rd_ok;
            end
            SCP_OP_VERIFY_WRITE: begin
                chk_zf = wr_ok;
            end
            SCP_OP_LOAD_LIMIT: begin
                chk_zf     = lim_ok;
                chk_result = lim_ok ? op_limit : 32'h0000_0000;
            end
            SCP_OP_LOAD_RIGHTS: begin
                chk_zf     = rgt_ok;
                chk_result = rgt_ok ? op_rights : 32'h0000_0000;
            end
            SCP_OP_DATA_ACCESS: begin
                chk_fault = !(data_ok || d_conf);
            end
            SCP_OP_CALL_CODE: begin
                chk_fault = !call_ok;
            end
            default: begin
                chk_fault = 1'b1;
            end
        endcase
    end

    // descriptor address from table choice and index
    wire        sel_local  = seg_sel_i[SCP_SEL_TABLE];
    wire [31:0] table_base = sel_local ? ldt_base_q : gdt_base_q;
    wire [31:0] entry_off  = {16'h0000, seg_sel_i[15:SCP_SEL_INDEX_LSB], 3'h0};
    wire        fixed_mode = (mode_q != SCP_MODE_PROT);
    wire        load_take  = seg_load_i && (state_q == SCP_ST_IDLE);
    wire        fetch_done = (state_q == SCP_ST_FETCH) && desc_ack_i;
    wire        fetch_np   = fetch_done && !desc_data_i[SCP_D_P];
    wire [31:0] fix_base   = {12'h000, seg_sel_i, 4'h0};
    wire [11:0] fix_attr   = (mode_q == SCP_MODE_V86) ? SCP_ATTR_V86 : SCP_ATTR_REAL;
    wire [19:0] d_lim20    = {desc_data_i[SCP_D_LIMHI_LSB +: 4], desc_data_i[SCP_D_LIMLO_LSB +: 16]};
    wire [31:0] d_limit    = desc_data_i[SCP_D_G] ? {d_lim20, SCP_LIM_FILL} : {12'h000, d_lim20};
    wire [31:0] d_base     = {desc_data_i[SCP_D_BASEHI_LSB +: 8], desc_data_i[SCP_D_BASELO_LSB +: 24]};
    wire [11:0] d_attr     = {desc_data_i[SCP_D_FLAGS_LSB +: 4], desc_data_i[SCP_D_TYPE_LSB +: 8]};

    // fetch sequencer: protected loads wait for the descriptor
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q     <= SCP_ST_IDLE;
            pend_idx_q  <= 3'h0;
            pend_sel_q  <= 16'h0000;
            desc_addr_o <= 32'h0000_0000;
        end else begin
            case (state_q)
                SCP_ST_IDLE: begin
                    if (load_take && !fixed_mode) begin
                        state_q     <= SCP_ST_FETCH;
                        pend_idx_q  <= seg_idx_i;
                        pend_sel_q  <= seg_sel_i;
                        desc_addr_o <= 32'(table_base + entry_off);
                    end
                end
                SCP_ST_FETCH: begin
                    if (desc_ack_i) begin
                        state_q <= SCP_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SCP_ST_IDLE;
                end
            endcase
        end
    end
    assign desc_req_o = (state_q == SCP_ST_FETCH);
    assign seg_busy_o = (state_q == SCP_ST_FETCH);

    // cache fill; a not-present descriptor leaves the old entry intact
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < SCP_NUM_SEGS; i++) begin
                seg_base_q[i]  <= 32'h0000_0000;
                seg_limit_q[i] <= SCP_FIXED_LIMIT;
                seg_attr_q[i]  <= SCP_ATTR_REAL;
            end
        end else if (load_take && fixed_mode) begin
            seg_base_q[seg_idx_i]  <= fix_base;
            seg_limit_q[seg_idx_i] <= SCP_FIXED_LIMIT;
            seg_attr_q[seg_idx_i]  <= fix_attr;
        end else if (fetch_done && !fetch_np) begin
            seg_base_q[pend_idx_q]  <= d_base;
            seg_limit_q[pend_idx_q] <= d_limit;
            seg_attr_q[pend_idx_q]  <= d_attr;
        end
    end

    // cache readout is registered, one cycle behind the index
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cache_base_o  <= 32'h0000_0000;
            cache_limit_o <= 32'h0000_0000;
            cache_attr_o  <= 12'h000;
        end else begin
            cache_base_o  <= seg_base_q[cache_idx_i];
            cache_limit_o <= seg_limit_q[cache_idx_i];
            cache_attr_o  <= seg_attr_q[cache_idx_i];
        end
    end

    // op answer; a faulting op reports no zero flag and no result
    wire op_fault  = op_valid_i && chk_fault;
    wire any_fault = op_fault || fetch_np;
    wire [7:0] any_vec = op_fault ? SCP_VEC_GP : SCP_VEC_NP;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            op_done_o   <= 1'b0;
            op_zf_o     <= 1'b0;
            op_result_o <= 32'h0000_0000;
            fault_o     <= 1'b0;
            fault_vec_o <= 8'h00;
        end else begin
            op_done_o   <= op_valid_i;
            op_zf_o     <= op_valid_i && !chk_fault && chk_zf;
            op_result_o <= (op_valid_i && !chk_fault) ? chk_result : 32'h0000_0000;
            fault_o     <= any_fault;
            fault_vec_o <= any_fault ? any_vec : 8'h00;
        end
    end

    // control registers and privilege state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mode_q          <= SCP_MODE_REAL;
            task32_q        <= 1'b0;
            io_priv_level_q <= SCP_LVL_KERNEL;
            if_q            <= 1'b0;
            task_lvl_q      <= SCP_LVL_KERNEL;
            gdt_base_q      <= 32'h0000_0000;
            ldt_base_q      <= 32'h0000_0000;
            last_vec_q      <= 8'h00;
            fault_cnt_q     <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                mode_q   <= reg_wdata_i[SCP_CTRL_MODE_LSB +: 2];
                task32_q <= reg_wdata_i[SCP_CTRL_TASK32];
            end
            if (wr_flags) begin
                io_priv_level_q <= reg_wdata_i[SCP_FLAGS_IOLVL +: 2];
                if_q            <= reg_wdata_i[SCP_FLAGS_IF];
            end
            // the checked op lands after any software write of the same cycle
            if (op_valid_i && chk_if_we) begin
                if_q <= chk_if_val;
            end
            if (wr_gdt) begin
                gdt_base_q <= reg_wdata_i;
            end
            if (wr_ldt) begin
                ldt_base_q <= reg_wdata_i;
            end
            if (gate_xfer_i && mode_q == SCP_MODE_PROT) begin
                task_lvl_q <= gate_lvl_i;
            end
            if (any_fault) begin
                last_vec_q  <= any_vec;
                fault_cnt_q <= 16'(fault_cnt_q + 16'h0001);
            end
        end
    end
    assign current_priv_level_o = cur_lvl;
    assign intr_flag_o          = if_q;

    // register read mux, data one cycle later
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            SCP_REG_CTRL:     rd_mux = {29'h0, task32_q, mode_q};
            SCP_REG_FLAGS:    rd_mux = {18'h0, io_priv_level_q, 2'h0, if_q, 9'h0};
            SCP_REG_GDT_BASE: rd_mux = gdt_base_q;
            SCP_REG_LDT_BASE: rd_mux = ldt_base_q;
            SCP_REG_STATUS:   rd_mux = {16'h0, last_vec_q, 5'h0, seg_busy_o, cur_lvl};
            SCP_REG_FAULTS:   rd_mux = {16'h0, fault_cnt_q};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_real_cache_base:
        assert property (seg_load_i && !seg_busy_o && mode_q == SCP_MODE_REAL |=>
            seg_base_q[$past(seg_idx_i)] == {12'h000, $past(seg_sel_i), 4'h0} &&
            seg_limit_q[$past(seg_idx_i)] == SCP_FIXED_LIMIT)
        else $error("real mode cache not fixed");
    a_real_level_zero:
        assert property (mode_q == SCP_MODE_REAL |-> current_priv_level_o == SCP_LVL_KERNEL)
        else $error("real mode level not zero");
    a_prot_fetch_start:
        assert property (seg_load_i && !seg_busy_o && mode_q == SCP_MODE_PROT |=> desc_req_o)
        else $error("descriptor fetch not started");
    a_fetch_req_hold:
        assert property (desc_req_o && !desc_ack_i |=> desc_req_o)
        else $error("descriptor request dropped early");
    a_v86_level_three:
        assert property (mode_q == SCP_MODE_V86 |-> current_priv_level_o == SCP_LVL_USER)
        else $error("v86 level not three");
    a_legacy_io_fault:
        assert property (op_valid_i && op_code_i == SCP_OP_IO && !io_pass && !task32_q |=>
            fault_o && fault_vec_o == SCP_VEC_GP && !op_zf_o)
        else $error("legacy io did not fault");
    a_intr_op_fault:
        assert property (op_valid_i && op_code_i == SCP_OP_SET_INTR_FLAG && !io_pass && !wr_flags |=>
            fault_o && intr_flag_o == $past(intr_flag_o))
        else $error("intr op not blocked");
    a_lock_no_fault:
        assert property (op_valid_i && op_code_i == SCP_OP_LOCK && !fetch_np |=> !fault_o)
        else $error("lock prefix faulted");
    a_flags_if_hold:
        assert property (op_valid_i && op_code_i == SCP_OP_FLAGS_LOAD && !io_pass && !wr_flags |=>
            intr_flag_o == $past(intr_flag_o) && !(fault_o && fault_vec_o == SCP_VEC_GP))
        else $error("flags load changed intr flag");
    a_data_level_fault:
        assert property (op_valid_i && op_code_i == SCP_OP_DATA_ACCESS &&
            effective_priv_level > descriptor_priv_level && !d_conf |=> fault_o)
        else $error("data access not faulted");
    a_adjust_zero_flag:
        assert property (op_valid_i && op_code_i == SCP_OP_ADJUST_SELECTOR_PRIV |=>
            op_zf_o == ($past(op_reg_rq_i) > $past(op_sel_i[1:0])) && op_result_o[1:0] >= $past(op_reg_rq_i))
        else $error("adjust result wrong");
endmodule

// [scp_desc_mem.sv]
`timescale 1ns/1ps
// far-side descriptor memory: answers a fetch after wait_i idle cycles
module scp_desc_mem #(
    parameter logic [63:0] DESC = 64'h0
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [3:0]  wait_i,
    output logic             ack_o,
    output logic [63:0]      data_o
);
    logic [3:0]  cnt_q;
    logic [63:0] junk_q;
    // ack is a one-cycle pulse; data bus toggles outside the ack cycle
    always_ff @(posedge clk_i) begin
        junk_q <= rst_i ? 64'h5a5a_0ff0_c3c3_1234 : {junk_q[62:0], ~junk_q[63]};
        if (rst_i || !req_i || ack_o) begin
            cnt_q <= 4'h0;
            ack_o <= 1'b0;
        end else if (cnt_q == wait_i) begin
            ack_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // stale data never shown, so a late capture is caught
    assign data_o = ack_o ? DESC : junk_q;
endmodule

// [tb_scp_priv_check.sv]
`timescale 1ns/1ps
module tb_scp_priv_check;
    import scp_pkg::*;
    localparam logic [63:0] DESC = 64'h1240_9234_5678_abcd;
    logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, seg_load_i = 0, seg_busy_o, desc_req_o, desc_ack_i;
    logic gate_xfer_i = 0, op_valid_i = 0, op_bitmap_ok_i = 0, op_if_i = 0, op_done_o, op_zf_o, fault_o, intr_flag_o;
    logic [7:0] reg_addr_i = 0, fault_vec_o;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, desc_addr_o, cache_base_o, cache_limit_o, op_result_o;
    logic [2:0] seg_idx_i = 0, cache_idx_i = 0;
    logic [15:0] seg_sel_i = 0, op_sel_i = 0, sel;
    logic [63:0] desc_data_i, op_desc_i = 0;
    logic [11:0] cache_attr_o;
    logic [1:0] gate_lvl_i = 0, op_reg_rq_i = 0, current_priv_level_o, rq;
    logic [3:0] wait_n = 0;
    scp_op_t op_code_i = SCP_OP_IO;
    logic [26:0] expq[$];
    logic [26:0] e;
    int failures = 0, checks_done = 0;
    scp_priv_check i_dut (.*);
    scp_desc_mem #(.DESC(DESC)) i_mem (.clk_i(mclk_i), .rst_i(rst_i), .req_i(desc_req_o), .addr_i(desc_addr_o),
        .wait_i(wait_n), .ack_o(desc_ack_i), .data_o(desc_data_i));
    initial forever #25 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        reg_rd_i <= 1; reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // note the expected answer, then present the op for one cycle
    task automatic op(input scp_op_t c, input logic [15:0] s, input logic [1:0] r, input logic bm, input logic f,
                      input logic chkzf, input logic flt, input logic zf, input logic [15:0] res);
        expq.push_back({chkzf, flt, flt ? SCP_VEC_GP : 8'h00, zf, res});
        @(posedge mclk_i);
        op_valid_i <= 1; op_code_i <= c; op_sel_i <= s; op_reg_rq_i <= r; op_bitmap_ok_i <= bm; op_if_i <= f;
        @(posedge mclk_i);
        op_valid_i <= 0;
    endtask
    // load a segment, wait out any fetch, then read back its cache
    task automatic seg(input logic [15:0] s, input logic [31:0] b, input logic [31:0] l, input logic [11:0] at);
        @(posedge mclk_i);
        seg_load_i <= 1; seg_sel_i <= s; seg_idx_i <= 3'h2; cache_idx_i <= 3'h2;
        @(posedge mclk_i);
        seg_load_i <= 0;
        for (int i = 0; i < 40; i++) begin
            #1 if (!seg_busy_o) break;
            @(posedge mclk_i);
        end
        repeat (2) @(posedge mclk_i);
        #1 chk(cache_base_o, b);
        chk(cache_limit_o, l);
        chk({20'h0, cache_attr_o}, {20'h0, at});
    endtask
    // answer monitor: oldest note against each op_done pulse
    always @(posedge mclk_i) if (op_done_o === 1'b1) begin
        e = expq.pop_front();
        chk({23'h0, fault_o, fault_vec_o}, {23'h0, e[25], e[24:17]});
        if (e[26]) chk({15'h0, op_zf_o, op_result_o[15:0]}, {15'h0, e[16:0]});
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hb4804293));
        repeat (12) @(posedge mclk_i);
        rst_i <= 0;
        rd(8'h40, 32'h0);
        sel = 16'($urandom());
        seg(sel, {12'h0, sel, 4'h0}, SCP_FIXED_LIMIT, SCP_ATTR_REAL);
        chk({30'h0, current_priv_level_o}, 32'h0);
        op(SCP_OP_IO, 0, 0, 0, 0, 0, 0, 0, 0);
        wr(SCP_REG_CTRL, {30'h0, SCP_MODE_V86});
        seg(~sel, {12'h0, ~sel, 4'h0}, SCP_FIXED_LIMIT, SCP_ATTR_V86);
        chk({30'h0, current_priv_level_o}, 32'h3);
        op(SCP_OP_IO, 0, 0, 0, 0, 0, 1, 0, 0);
        wr(SCP_REG_CTRL, {30'h0, SCP_MODE_PROT});
        wr(SCP_REG_GDT_BASE, 32'h1000);
        wr(SCP_REG_LDT_BASE, 32'h2000);
        for (int t = 0; t < 2; t++) begin
            wait_n <= 4'(t * 7);
            sel = {13'($urandom()), t[0], 2'h0};
            fork
                seg(sel, 32'h1234_5678, 32'h0000_abcd, 12'h492);
                begin
                    wait (desc_req_o === 1'b1);
                    #1 chk(desc_addr_o, (t ? 32'h2000 : 32'h1000) + {16'h0, sel[15:3], 3'h0});
                end
            join
        end
        @(posedge mclk_i);
        gate_xfer_i <= 1; gate_lvl_i <= 2'h2;
        @(posedge mclk_i);
        gate_xfer_i <= 0;
        #1 chk({30'h0, current_priv_level_o}, 32'h2);
        wr(SCP_REG_FLAGS, 32'h1200);
        rd(SCP_REG_STATUS, 32'h0000_0d02);
        op(SCP_OP_IO, 0, 0, 0, 0, 0, 1, 0, 0);
        op(SCP_OP_CLEAR_INTR_FLAG, 0, 0, 0, 0, 0, 1, 0, 0);
        op(SCP_OP_SET_INTR_FLAG, 0, 0, 0, 0, 0, 1, 0, 0);
        op(SCP_OP_LOCK, 0, 0, 0, 0, 0, 0, 0, 0);
        op(SCP_OP_FLAGS_LOAD, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, intr_flag_o}, 32'h1);
        wr(SCP_REG_CTRL, 32'h5);
        op(SCP_OP_IO, 0, 0, 1, 0, 0, 0, 0, 0);
        op(SCP_OP_IO, 0, 0, 0, 0, 0, 1, 0, 0);
        wr(SCP_REG_FLAGS, 32'h2000);
        op(SCP_OP_IO, 0, 0, 0, 0, 0, 0, 0, 0);
        op(SCP_OP_FLAGS_LOAD, 0, 0, 0, 1, 0, 0, 0, 0);
        repeat (2) @(posedge mclk_i);
        chk({31'h0, intr_flag_o}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            sel = 16'($urandom());
            rq = 2'($urandom());
            op(SCP_OP_ADJUST_SELECTOR_PRIV, sel, rq, 0, 0, 1, 0, rq > sel[1:0],
               {sel[15:2], (rq > sel[1:0]) ? rq : sel[1:0]});
        end
        // level 2 writable data descriptor, current level 2
        op_desc_i <= {DESC[63:48], 8'hd2, DESC[39:0]};
        op(SCP_OP_VERIFY_READ, 0, 0, 0, 0, 1, 0, 1, 0);
        op(SCP_OP_VERIFY_WRITE, 3, 0, 0, 0, 1, 0, 0, 0);
        op(SCP_OP_LOAD_LIMIT, 0, 0, 0, 0, 1, 0, 1, 16'habcd);
        op(SCP_OP_LOAD_RIGHTS, 0, 0, 0, 0, 1, 0, 1, 16'hd200);
        op(SCP_OP_DATA_ACCESS, 3, 0, 0, 0, 1, 1, 0, 0);
        op(SCP_OP_CALL_CODE, 0, 0, 0, 0, 1, 0, 0, 0);
        // level 3 descriptor: call from level 2 refused, data reachable
        op_desc_i <= {DESC[63:48], 8'hf2, DESC[39:0]};
        op(SCP_OP_CALL_CODE, 0, 0, 0, 0, 1, 1, 0, 0);
        op(SCP_OP_DATA_ACCESS, 0, 0, 0, 0, 1, 0, 0, 0);
        repeat (3) @(posedge mclk_i);
        chk(32'(expq.size()), 32'h0);
        stop_test();
    end
endmodule
